// ### logic/crt_pkg.sv
// constants and types shared by the capture/reload timer
package crt_pkg;

  // ---------------------------------------------------------------
  // timing: oscillator clocks per machine cycle and per state time
  // ---------------------------------------------------------------
  localparam int unsigned CRT_OSC_PER_MACHINE = 12;
  localparam int unsigned CRT_OSC_PER_STATE   = 2;
  localparam logic [3:0]  CRT_MACHINE_LAST    = 4'(CRT_OSC_PER_MACHINE - 1);
  localparam logic [3:0]  CRT_STATE_LAST      = 4'(CRT_OSC_PER_STATE - 1);

  // ---------------------------------------------------------------
  // control register bit positions
  // ---------------------------------------------------------------
  localparam int unsigned CRT_BIT_OVF   = 7;
  localparam int unsigned CRT_BIT_EXTF  = 6;
  localparam int unsigned CRT_BIT_RXCLK = 5;
  localparam int unsigned CRT_BIT_TXCLK = 4;
  localparam int unsigned CRT_BIT_EXTEN = 3;
  localparam int unsigned CRT_BIT_RUN   = 2;
  localparam int unsigned CRT_BIT_CSEL  = 1;
  localparam int unsigned CRT_BIT_CNR   = 0;

  // ---------------------------------------------------------------
  // reset values and counter maximum
  // ---------------------------------------------------------------
  localparam logic [7:0]  CRT_CTRL_RST  = 8'h00;
  localparam logic [15:0] CRT_COUNT_RST = 16'h0000;
  localparam logic [15:0] CRT_CAP_RST   = 16'h0000;
  localparam logic [15:0] CRT_COUNT_MAX = 16'hffff;
  localparam logic [3:0]  CRT_DIV_RST   = 4'h0;

  // ---------------------------------------------------------------
  // operating modes, gray coded
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CRT_OFF     = 2'b00,
    CRT_RELOAD  = 2'b01,
    CRT_CAPTURE = 2'b11,
    CRT_BAUD    = 2'b10
  } crt_mode_t;

endpackage : crt_pkg

// ### logic/crt_prescaler.sv
// machine-cycle and state-time enable pulses from the oscillator clock
`timescale 1ns/1ps
module crt_prescaler
  import crt_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // enable pulses
  output logic      machine_tick,
  output logic      state_tick
);

  logic [3:0] div_r;

  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= CRT_DIV_RST;
    end else if (div_r == CRT_MACHINE_LAST) begin
      div_r <= CRT_DIV_RST;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // registered pulses
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      machine_tick <= 1'b0;
      state_tick   <= 1'b0;
    end else begin
      machine_tick <= (div_r == CRT_MACHINE_LAST);
      state_tick   <= ((div_r & CRT_STATE_LAST) == CRT_STATE_LAST);
    end
  end

endmodule : crt_prescaler

// ### logic/crt_timer.sv
// capture/reload timer: counter, capture/reload pair, control flags
// Operation
// - 16-bit counter, control, capture/reload byte pairs
// - select bit picks machine cycles (state times in baud) or events
// - mode from clock selects, capture bit, run
// - capture mode: free counter, overflow sets flag
// - enabled trigger edge captures count bytes
// - enabled trigger edge sets external flag
// - reload mode: rollover sets flag, loads pair
// - enabled trigger edge also reloads, sets flag
// - external enable clear: trigger pin ignored
// - baud mode: trigger edge never reloads
// - trigger pin usable as extra interrupt
// - clock selects force reload, ignore capture bit
// - baud timer counts every state time
// - baud rollover sets no overflow flag
`timescale 1ns/1ps
module crt_timer
  import crt_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // core writes
  input  wire logic [7:0] wr_data,
  input  wire logic       ctrl_wr,
  input  wire logic       count_low_wr,
  input  wire logic       count_high_wr,
  input  wire logic       cap_low_wr,
  input  wire logic       cap_high_wr,
  // pins
  input  wire logic       trigger_pin,
  input  wire logic       count_pin,
  // register read-back
  output logic [7:0]      timer_control_reg,
  output logic [7:0]      count_low_byte,
  output logic [7:0]      count_high_byte,
  output logic [7:0]      capture_reload_low,
  output logic [7:0]      capture_reload_high,
  // events
  output logic            irq,
  output logic            rollover_pulse
);

  import crt_pkg::*;

  logic        machine_tick;
  logic        state_tick;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] cap_r;
  logic [15:0] cap_nxt;
  logic        overflow_flag_r;
  logic        external_flag_r;
  logic        receive_clock_select_r;
  logic        transmit_clock_select_r;
  logic        external_enable_r;
  logic        run_bit_r;
  logic        counter_select_r;
  logic        capture_not_reload_r;
  logic        overflow_flag_nxt;
  logic        external_flag_nxt;
  logic        trig_smp_r;
  logic        cnt_smp_r;
  logic        trig_edge_r;
  logic        cnt_edge_r;
  logic        baud;
  logic        inc;
  logic        overflow;
  logic        trig_evt;
  logic        do_reload;
  logic        do_capture;
  crt_mode_t   mode;

  crt_prescaler u_prescaler (
    .clock        (clock),
    .reset_n      (reset_n),
    .machine_tick (machine_tick),
    .state_tick   (state_tick)
  );

  // ---------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------
  // high sample then low sample
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      trig_smp_r  <= 1'b1;
      cnt_smp_r   <= 1'b1;
      trig_edge_r <= 1'b0;
      cnt_edge_r  <= 1'b0;
    end else begin
      trig_edge_r <= machine_tick & trig_smp_r & ~trigger_pin;
      cnt_edge_r  <= machine_tick & cnt_smp_r & ~count_pin;
      if (machine_tick) begin
        trig_smp_r <= trigger_pin;
        cnt_smp_r  <= count_pin;
      end
    end
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  // either clock select means baud
  assign baud = receive_clock_select_r | transmit_clock_select_r;

  always_comb begin
    if (!run_bit_r) begin
      mode = CRT_OFF;
    end else if (baud) begin
      mode = CRT_BAUD;
    end else if (capture_not_reload_r) begin
      mode = CRT_CAPTURE;
    end else begin
      mode = CRT_RELOAD;
    end
  end

  // ---------------------------------------------------------------
  // count enable and events
  // ---------------------------------------------------------------
  always_comb begin
    case (mode)
      CRT_OFF: inc = 1'b0;
      CRT_BAUD: inc = counter_select_r ? cnt_edge_r : state_tick;
      CRT_RELOAD, CRT_CAPTURE: inc = counter_select_r ? cnt_edge_r : machine_tick;
      default: inc = 1'b0;
    endcase
  end

  assign overflow = inc & (count_r == CRT_COUNT_MAX);
  assign trig_evt = trig_edge_r & external_enable_r;
  // clock selects force reload on rollover
  assign do_reload  = (overflow & (baud | ~capture_not_reload_r))
                    | (trig_evt & ~baud & ~capture_not_reload_r);
  assign do_capture = trig_evt & ~baud & capture_not_reload_r;

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_comb begin
    count_nxt = count_r;
    if (inc) begin
      count_nxt = count_r + 16'h0001;
    end
    if (do_reload) begin
      count_nxt = cap_r;
    end
    if (count_low_wr) begin
      count_nxt[7:0] = wr_data;
    end
    if (count_high_wr) begin
      count_nxt[15:8] = wr_data;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= CRT_COUNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  // ---------------------------------------------------------------
  // capture/reload pair
  // ---------------------------------------------------------------
  always_comb begin
    cap_nxt = cap_r;
    if (cap_low_wr) begin
      cap_nxt[7:0] = wr_data;
    end
    if (cap_high_wr) begin
      cap_nxt[15:8] = wr_data;
    end
    if (do_capture) begin
      cap_nxt = count_r;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cap_r <= CRT_CAP_RST;
    end else begin
      cap_r <= cap_nxt;
    end
  end

  // ---------------------------------------------------------------
  // control register and flags
  // ---------------------------------------------------------------
  // no overflow flag in baud
  assign overflow_flag_nxt = (ctrl_wr ? wr_data[CRT_BIT_OVF] : overflow_flag_r) | (overflow & ~baud);
  // edge sets flag in every mode
  assign external_flag_nxt = (ctrl_wr ? wr_data[CRT_BIT_EXTF] : external_flag_r) | trig_evt;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      overflow_flag_r <= CRT_CTRL_RST[CRT_BIT_OVF];
      external_flag_r <= CRT_CTRL_RST[CRT_BIT_EXTF];
    end else begin
      overflow_flag_r <= overflow_flag_nxt;
      external_flag_r <= external_flag_nxt;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      receive_clock_select_r  <= CRT_CTRL_RST[CRT_BIT_RXCLK];
      transmit_clock_select_r <= CRT_CTRL_RST[CRT_BIT_TXCLK];
      external_enable_r       <= CRT_CTRL_RST[CRT_BIT_EXTEN];
      run_bit_r               <= CRT_CTRL_RST[CRT_BIT_RUN];
      counter_select_r        <= CRT_CTRL_RST[CRT_BIT_CSEL];
      capture_not_reload_r    <= CRT_CTRL_RST[CRT_BIT_CNR];
    end else if (ctrl_wr) begin
      receive_clock_select_r  <= wr_data[CRT_BIT_RXCLK];
      transmit_clock_select_r <= wr_data[CRT_BIT_TXCLK];
      external_enable_r       <= wr_data[CRT_BIT_EXTEN];
      run_bit_r               <= wr_data[CRT_BIT_RUN];
      counter_select_r        <= wr_data[CRT_BIT_CSEL];
      capture_not_reload_r    <= wr_data[CRT_BIT_CNR];
    end
  end

  // ---------------------------------------------------------------
  // interrupt and rollover outputs
  // ---------------------------------------------------------------
  // request while either flag set
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq            <= 1'b0;
      rollover_pulse <= 1'b0;
    end else begin
      irq            <= overflow_flag_nxt | external_flag_nxt;
      rollover_pulse <= overflow;
    end
  end

  assign timer_control_reg   = {overflow_flag_r, external_flag_r, receive_clock_select_r,
                                transmit_clock_select_r, external_enable_r, run_bit_r,
                                counter_select_r, capture_not_reload_r};
  assign count_low_byte      = count_r[7:0];
  assign count_high_byte     = count_r[15:8];
  assign capture_reload_low  = cap_r[7:0];
  assign capture_reload_high = cap_r[15:8];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence baud_steady_s;
    run_bit_r && baud && !counter_select_r && !ctrl_wr && !count_low_wr && !count_high_wr
      && !trig_evt && (count_r < 16'hfffd);
  endsequence

  sequence count_quiet_s;
    !count_low_wr && !count_high_wr;
  endsequence

  capture_ovf_flag_a: assert property (overflow && !baud |=> overflow_flag_r)
    else $error("overflow did not set the overflow flag");
  capture_copy_a: assert property (do_capture && !cap_low_wr && !cap_high_wr |=> cap_r == $past(count_r))
    else $error("trigger edge did not capture the count");
  ext_flag_set_a: assert property (trig_evt |=> external_flag_r ##0 irq)
    else $error("trigger edge did not set the external flag");
  reload_on_ovf_a: assert property (overflow && !baud && !capture_not_reload_r ##0 count_quiet_s
                                    |=> count_r == $past(cap_r) && overflow_flag_r)
    else $error("rollover did not reload the counter");
  trig_reload_a: assert property (trig_evt && !baud && !capture_not_reload_r ##0 count_quiet_s
                                  |=> count_r == $past(cap_r))
    else $error("trigger edge did not reload the counter");
  trig_ignored_a: assert property (!external_enable_r && !ctrl_wr && !cap_low_wr && !cap_high_wr
                                   |=> $stable(cap_r) && !$rose(external_flag_r))
    else $error("trigger pin acted while disabled");
  baud_no_trig_a: assert property (trig_evt && baud && !overflow ##0 count_quiet_s
                                   |=> count_r == $past(count_r) + 16'(($past(inc))))
    else $error("trigger edge reloaded in baud mode");
  baud_reload_a: assert property (overflow && baud ##0 count_quiet_s |=> count_r == $past(cap_r))
    else $error("baud rollover did not reload");
  baud_rate_a: assert property (baud_steady_s [*2] |=> count_r == $past(count_r, 2) + 16'h0001)
    else $error("baud timer not counting once per state time");
  baud_no_ovf_a: assert property (baud && !ctrl_wr |=> !$rose(overflow_flag_r))
    else $error("baud rollover set the overflow flag");
  irq_or_a: assert property (irq == (overflow_flag_r | external_flag_r))
    else $error("interrupt request not the OR of the flags");
  edge_sample_a: assert property (trig_edge_r |-> $past(machine_tick) && !$past(trigger_pin))
    else $error("trigger edge outside a machine-cycle sample");

endmodule : crt_timer

// ### testbench/crt_pin_source.sv
// trigger and count pin sources driven from the bench
`timescale 1ns/1ps
module crt_pin_source (
  // clock
  input  wire logic clock,
  // pins
  output logic      trigger_pin,
  output logic      count_pin
);
  initial begin
    trigger_pin = 1'b1;
    count_pin   = 1'b1;
  end

  // each level held past a machine cycle
  task automatic pulse(input logic trig);
    @(negedge clock);
    if (trig) trigger_pin = 1'b0;
    else count_pin = 1'b0;
    repeat (14) @(negedge clock);
    trigger_pin = 1'b1;
    count_pin   = 1'b1;
    repeat (14) @(negedge clock);
  endtask : pulse
endmodule : crt_pin_source

// ### testbench/crt_timer_tb.sv
// self-checking bench for the capture/reload timer
`timescale 1ns/1ps
module crt_timer_tb;
  import crt_pkg::*;
  logic       clock;
  logic       reset_n;
  logic [7:0] wr_data;
  logic [4:0] wr_sel;
  logic [7:0] timer_control_reg;
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [7:0] capture_reload_low;
  logic [7:0] capture_reload_high;
  logic       irq;
  logic       rollover_pulse;
  logic       trigger_pin;
  logic       count_pin;
  int         checked = 0;
  int         mismatches = 0;
  logic [7:0] codes [14] = '{8'h00, 8'h08, 8'h01, 8'h09, 8'h02, 8'h0a, 8'h03,
                             8'h0b, 8'h34, 8'h36, 8'h24, 8'h26, 8'h14, 8'h16};

  crt_timer u_dut (
    .clock(clock), .reset_n(reset_n), .wr_data(wr_data),
    .ctrl_wr(wr_sel[0]), .count_low_wr(wr_sel[1]), .count_high_wr(wr_sel[2]),
    .cap_low_wr(wr_sel[3]), .cap_high_wr(wr_sel[4]),
    .trigger_pin(trigger_pin), .count_pin(count_pin),
    .timer_control_reg(timer_control_reg), .count_low_byte(count_low_byte),
    .count_high_byte(count_high_byte), .capture_reload_low(capture_reload_low),
    .capture_reload_high(capture_reload_high), .irq(irq), .rollover_pulse(rollover_pulse)
  );

  crt_pin_source u_src (.clock(clock), .trigger_pin(trigger_pin), .count_pin(count_pin));

  // -------------------------------------------------------------
  // access tasks
  // -------------------------------------------------------------
  function automatic logic [15:0] cnt();
    return {count_high_byte, count_low_byte};
  endfunction : cnt

  function automatic logic [15:0] cap();
    return {capture_reload_high, capture_reload_low};
  endfunction : cap

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rng(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    chk(16'(v >= lo && v < hi), 16'h0001);
  endtask : rng

  task automatic wr(input int s, input logic [7:0] d);
    @(negedge clock);
    wr_sel  = 5'(1 << s);
    wr_data = d;
    @(negedge clock);
    wr_sel  = 5'h00;
  endtask : wr

  task automatic wr16(input int s, input logic [15:0] v);
    wr(s + 1, v[15:8]);
    wr(s, v[7:0]);
  endtask : wr16

  task automatic wait_roll();
    int n;
    n = 0;
    @(negedge clock);
    while (rollover_pulse !== 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 2000) begin
      mismatches++;
      end_of_test();
    end
  endtask : wait_roll

  task automatic done(input string t);
    $display("test %s done", t);
  endtask : done

  // -------------------------------------------------------------
  // clock and sequence
  // -------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    reset_n = 1'b0;
    wr_data = 8'h00;
    wr_sel  = 5'h00;
    repeat (12) @(posedge clock);
    @(negedge clock);
    reset_n = 1'b1;
    chk({timer_control_reg, irq, rollover_pulse, 6'h00}, 16'h0000);
    chk(cnt(), 16'h0000);
    chk(cap(), 16'h0000);
    done("reset");
    wr(0, 8'h00);
    wr16(3, 16'h1234);
    wr16(1, 16'hfffe);
    chk(cnt(), 16'hfffe);
    chk(cap(), 16'h1234);
    wr(0, 8'h04);
    wait_roll();
    chk(cnt(), 16'h1234);
    chk(16'(timer_control_reg[CRT_BIT_OVF]), 16'h0001);
    chk(16'(irq), 16'h0001);
    repeat (12) @(negedge clock);
    chk(cnt(), 16'h1235);
    wr(0, 8'h04);
    chk(16'(timer_control_reg[CRT_BIT_OVF]), 16'h0000);
    chk(16'(irq), 16'h0000);
    wr(0, 8'h08);
    wr(0, 8'h0c);
    wr16(1, 16'h8000);
    u_src.pulse(1'b1);
    rng(cnt(), 16'h1234, 16'h123a);
    chk(16'(timer_control_reg[CRT_BIT_EXTF]), 16'h0001);
    chk(16'(irq), 16'h0001);
    done("reload");
    wr(0, 8'h01);
    wr16(1, 16'hfffe);
    wr(0, 8'h05);
    wait_roll();
    chk(cnt(), 16'h0000);
    chk(16'(timer_control_reg[CRT_BIT_OVF]), 16'h0001);
    chk(cap(), 16'h1234);
    wr(0, 8'h05);
    u_src.pulse(1'b1);
    chk(16'(timer_control_reg[CRT_BIT_EXTF]), 16'h0000);
    chk(cap(), 16'h1234);
    wr(0, 8'h09);
    wr(0, 8'h0d);
    wr16(1, 16'h0100);
    u_src.pulse(1'b1);
    rng(cap(), 16'h0100, 16'h0104);
    chk(16'(cnt() >= cap()), 16'h0001);
    chk(16'(timer_control_reg[CRT_BIT_EXTF]), 16'h0001);
    done("capture");
    wr(0, 8'h03);
    wr16(1, 16'h0000);
    wr(0, 8'h07);
    repeat (3) u_src.pulse(1'b0);
    chk(cnt(), 16'h0003);
    done("counter");
    wr(0, 8'h00);
    wr16(3, 16'hfff0);
    wr16(1, 16'hfffe);
    wr(0, 8'h35);
    wait_roll();
    chk(cnt(), 16'hfff0);
    chk(16'(timer_control_reg[CRT_BIT_OVF]), 16'h0000);
    chk(16'(irq), 16'h0000);
    repeat (10) @(negedge clock);
    chk(cnt(), 16'hfff5);
    wr(0, 8'h1e);
    wr16(1, 16'h1000);
    u_src.pulse(1'b1);
    chk(cnt(), 16'h1000);
    chk(16'(timer_control_reg[CRT_BIT_EXTF]), 16'h0001);
    chk(16'(irq), 16'h0001);
    done("baud");
    foreach (codes[i]) begin
      wr(0, codes[i]);
      chk(16'(timer_control_reg), 16'(codes[i]));
    end
    done("codes");
    end_of_test();
  end
endmodule : crt_timer_tb
